// ### verilog/link_cfg_params.svh
`ifndef LINK_CFG_PARAMS_SVH
`define LINK_CFG_PARAMS_SVH

`define ADDR_LANE_COUNT_SCRAMBLE 12'h453
`define ADDR_OCTETS_PER_FRAME_M1 12'h454
`define ADDR_FRAMES_PER_MULTIFRAME 12'h455
`define ADDR_CONVERTER_COUNT 12'h456
`define ADDR_RESOLUTION_CTRL 12'h457
`define ADDR_SUBCLASS_SAMPLE_BITS 12'h458
`define ADDR_VERSION_SAMPLES 12'h459
`define ADDR_DENSITY_CTRL_WORDS 12'h45a
`define ADDR_LANE_DESKEW_MASK 12'h46c
`define ADDR_OCTETS_PER_FRAME_ACTUAL 12'h476
`define ADDR_LANE_ENABLE_MASK 12'h47d

`define SCRAMBLE_BIT 7
`define HIGH_DENSITY_BIT 7
`define COUNT_FIELD_MSB 4
`define CLASS_FIELD_LSB 5
`define RESET_VALUE 8'h00

`endif

// ### verilog/link_cfg_pkg.sv
package link_cfg_pkg;

    typedef enum logic [1:0] {
        subclass_0,
        subclass_1,
        subclass_other
    } subclass_e;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [11:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic scramble_en;
        logic [5:0] lanes;
        logic [8:0] octets_per_frame;
        logic [5:0] frames_per_multiframe;
        logic [8:0] converters;
        subclass_e subclass;
        logic [5:0] samples_per_frame;
        logic high_density;
        logic [7:0] deskew_lanes;
        logic [7:0] enabled_lanes;
    } link_params_s;

endpackage

// ### verilog/jesd_link_param_config.sv
`timescale 1ns/1ps
`include "link_cfg_params.svh"

module jesd_link_param_config (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input link_cfg_pkg::reg_req_s req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output link_cfg_pkg::link_params_s params_o
);
    import link_cfg_pkg::*;

    localparam int NUM_REGS = 11;

    // Storage slot of each mapped register, shared by the address match and the readback select
    localparam logic [3:0] SLOT_LANE_COUNT = 4'd0;
    localparam logic [3:0] SLOT_OCTETS_M1 = 4'd1;
    localparam logic [3:0] SLOT_FRAMES = 4'd2;
    localparam logic [3:0] SLOT_CONVERTERS = 4'd3;
    localparam logic [3:0] SLOT_RESOLUTION = 4'd4;
    localparam logic [3:0] SLOT_SUBCLASS = 4'd5;
    localparam logic [3:0] SLOT_VERSION = 4'd6;
    localparam logic [3:0] SLOT_DENSITY = 4'd7;
    localparam logic [3:0] SLOT_DESKEW = 4'd8;
    localparam logic [3:0] SLOT_OCTETS_ACTUAL = 4'd9;
    localparam logic [3:0] SLOT_LANE_ENABLE = 4'd10;

    logic [7:0] lane_count_scramble;
    logic [7:0] octets_per_frame_m1;
    logic [7:0] frames_per_multiframe;
    logic [7:0] converter_count;
    logic [7:0] resolution_ctrl;
    logic [7:0] subclass_sample_bits;
    logic [7:0] version_samples;
    logic [7:0] density_ctrl_words;
    logic [7:0] lane_deskew_mask;
    logic [7:0] octets_per_frame_actual;
    logic [7:0] lane_enable_mask;
    wire [NUM_REGS-1:0] sel_vec;

    // One-hot match to slot number; no match gives slot 0, which the hit term masks off
    function automatic logic [3:0] slot_of(input logic [NUM_REGS-1:0] onehot);
        logic [3:0] slot;
        slot = 4'd0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (onehot[i]) begin
                slot = 4'(i);
            end
        end
        return slot;
    endfunction

    // Count fields are stored minus one; one bit wider so a full field plus one cannot wrap
    function automatic logic [5:0] plus_one5(input logic [7:0] v);
        return {1'b0, v[`COUNT_FIELD_MSB:0]} + 6'd1;
    endfunction

    function automatic logic [8:0] plus_one8(input logic [7:0] v);
        return {1'b0, v} + 9'd1;
    endfunction

    // Class codes above one stay apart so the deframer can refuse them
    function automatic subclass_e decode_class(input logic [2:0] field);
        unique case (field)
            3'h0: return subclass_0;
            3'h1: return subclass_1;
            default: return subclass_other;
        endcase
    endfunction

    // Address match
    assign sel_vec[SLOT_LANE_COUNT] = (req_i.addr == `ADDR_LANE_COUNT_SCRAMBLE);
    assign sel_vec[SLOT_OCTETS_M1] = (req_i.addr == `ADDR_OCTETS_PER_FRAME_M1);
    assign sel_vec[SLOT_FRAMES] = (req_i.addr == `ADDR_FRAMES_PER_MULTIFRAME);
    assign sel_vec[SLOT_CONVERTERS] = (req_i.addr == `ADDR_CONVERTER_COUNT);
    assign sel_vec[SLOT_RESOLUTION] = (req_i.addr == `ADDR_RESOLUTION_CTRL);
    assign sel_vec[SLOT_SUBCLASS] = (req_i.addr == `ADDR_SUBCLASS_SAMPLE_BITS);
    assign sel_vec[SLOT_VERSION] = (req_i.addr == `ADDR_VERSION_SAMPLES);
    assign sel_vec[SLOT_DENSITY] = (req_i.addr == `ADDR_DENSITY_CTRL_WORDS);
    assign sel_vec[SLOT_DESKEW] = (req_i.addr == `ADDR_LANE_DESKEW_MASK);
    assign sel_vec[SLOT_OCTETS_ACTUAL] = (req_i.addr == `ADDR_OCTETS_PER_FRAME_ACTUAL);
    assign sel_vec[SLOT_LANE_ENABLE] = (req_i.addr == `ADDR_LANE_ENABLE_MASK);

    // Unmapped addresses miss: writes are dropped, reads answer zero
    wire hit = |sel_vec;
    wire [3:0] idx = slot_of(sel_vec);
    wire wr_strobe = req_i.wr_en && hit;
    wire rd_strobe = req_i.rd_en && hit;
    wire [NUM_REGS-1:0] wr_slot = sel_vec & {NUM_REGS{wr_strobe}};

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lane_count_scramble <= `RESET_VALUE;
        end else if (wr_slot[SLOT_LANE_COUNT]) begin
            lane_count_scramble <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            octets_per_frame_m1 <= `RESET_VALUE;
        end else if (wr_slot[SLOT_OCTETS_M1]) begin
            octets_per_frame_m1 <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            frames_per_multiframe <= `RESET_VALUE;
        end else if (wr_slot[SLOT_FRAMES]) begin
            frames_per_multiframe <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            converter_count <= `RESET_VALUE;
        end else if (wr_slot[SLOT_CONVERTERS]) begin
            converter_count <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            resolution_ctrl <= `RESET_VALUE;
        end else if (wr_slot[SLOT_RESOLUTION]) begin
            resolution_ctrl <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            subclass_sample_bits <= `RESET_VALUE;
        end else if (wr_slot[SLOT_SUBCLASS]) begin
            subclass_sample_bits <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            version_samples <= `RESET_VALUE;
        end else if (wr_slot[SLOT_VERSION]) begin
            version_samples <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            density_ctrl_words <= `RESET_VALUE;
        end else if (wr_slot[SLOT_DENSITY]) begin
            density_ctrl_words <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lane_deskew_mask <= `RESET_VALUE;
        end else if (wr_slot[SLOT_DESKEW]) begin
            lane_deskew_mask <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            octets_per_frame_actual <= `RESET_VALUE;
        end else if (wr_slot[SLOT_OCTETS_ACTUAL]) begin
            octets_per_frame_actual <= req_i.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lane_enable_mask <= `RESET_VALUE;
        end else if (wr_slot[SLOT_LANE_ENABLE]) begin
            lane_enable_mask <= req_i.wdata;
        end
    end

    // Readback select; a read in the cycle of a write to the same register returns the old byte
    wire [NUM_REGS-1:0][7:0] all_bytes = {lane_enable_mask, octets_per_frame_actual, lane_deskew_mask,
        density_ctrl_words, version_samples, subclass_sample_bits, resolution_ctrl, converter_count,
        frames_per_multiframe, octets_per_frame_m1, lane_count_scramble};
    wire [7:0] next_rdata = rd_strobe ? all_bytes[idx] : 8'h00;
    wire next_rvalid = req_i.rd_en;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rdata_o <= next_rdata;
            rvalid_o <= next_rvalid;
        end
    end

    // Next decoded values, one per link parameter
    wire next_scramble = lane_count_scramble[`SCRAMBLE_BIT];
    wire [5:0] next_lanes = plus_one5(lane_count_scramble);
    wire [8:0] next_octets = plus_one8(octets_per_frame_m1);
    wire [5:0] next_frames = plus_one5(frames_per_multiframe);
    wire [8:0] next_converters = plus_one8(converter_count);
    wire subclass_e next_class = decode_class(subclass_sample_bits[7:`CLASS_FIELD_LSB]);
    wire [5:0] next_samples = plus_one5(version_samples);
    wire next_density = density_ctrl_words[`HIGH_DENSITY_BIT];
    wire [7:0] next_deskew = lane_deskew_mask;
    wire [7:0] next_enabled = lane_enable_mask;

    // Decoded view held in flip-flops so the deframer sees clean levels, one cycle behind the bytes
    logic scramble_flag;
    logic [5:0] lane_total;
    logic [8:0] octet_total;
    logic [5:0] frame_total;
    logic [8:0] converter_total;
    subclass_e class_sel;
    logic [5:0] sample_total;
    logic density_flag;
    logic [7:0] deskew_set;
    logic [7:0] enabled_set;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            scramble_flag <= 1'b0;
        end else begin
            scramble_flag <= next_scramble;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lane_total <= 6'h00;
        end else begin
            lane_total <= next_lanes;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            octet_total <= 9'h000;
        end else begin
            octet_total <= next_octets;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            frame_total <= 6'h00;
        end else begin
            frame_total <= next_frames;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            converter_total <= 9'h000;
        end else begin
            converter_total <= next_converters;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            class_sel <= subclass_0;
        end else begin
            class_sel <= next_class;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sample_total <= 6'h00;
        end else begin
            sample_total <= next_samples;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            density_flag <= 1'b0;
        end else begin
            density_flag <= next_density;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            deskew_set <= 8'h00;
        end else begin
            deskew_set <= next_deskew;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            enabled_set <= 8'h00;
        end else begin
            enabled_set <= next_enabled;
        end
    end

    assign params_o = '{
        scramble_en: scramble_flag,
        lanes: lane_total,
        octets_per_frame: octet_total,
        frames_per_multiframe: frame_total,
        converters: converter_total,
        subclass: class_sel,
        samples_per_frame: sample_total,
        high_density: density_flag,
        deskew_lanes: deskew_set,
        enabled_lanes: enabled_set
    };

endmodule // jesd_link_param_config

// ### testbench/link_cfg_sva.sv
`timescale 1ns/1ps
module link_cfg_sva import link_cfg_pkg::*; (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input link_cfg_pkg::reg_req_s req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input link_cfg_pkg::link_params_s params_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    wire logic [11:0] a = req_i.wr_en ? req_i.addr : 12'h000;
    wire logic [7:0] d = req_i.wdata;
    scramble_a: assert property (a == 12'h453 |-> ##2 params_o.scramble_en == $past(d[7], 2)) else $error("scr");
    lane_count_a: assert property (a == 12'h453 |-> ##2 params_o.lanes == $past(d[4:0], 2) + 6'h1) else $error("ln");
    octets_a: assert property (a == 12'h454 |-> ##2 params_o.octets_per_frame == $past(d, 2) + 9'h1) else $error("f");
    frames_a: assert property (a == 12'h455 |-> ##2 params_o.frames_per_multiframe == $past(d[4:0], 2) + 6'h1) else $error("k");
    subclass_a: assert property (a == 12'h458 && d[7:5] == 3'h1 |-> ##2 params_o.subclass == subclass_1) else $error("sc");
    density_a: assert property (a == 12'h45a |-> ##2 params_o.high_density == $past(d[7], 2)) else $error("hd");
    deskew_a: assert property (a == 12'h46c |-> ##2 params_o.deskew_lanes == $past(d, 2)) else $error("dk");
    lane_enable_a: assert property (a == 12'h47d |-> ##2 params_o.enabled_lanes == $past(d, 2)) else $error("en");
endmodule // link_cfg_sva

// ### testbench/jesd_link_param_config_tb_top.sv
`timescale 1ns/1ps
module jesd_link_param_config_tb_top;
    import link_cfg_pkg::*;
    logic clock_i = 0;
    logic sys_rst_i = 1;
    reg_req_s req_i = '0;
    logic [7:0] rdata_o;
    logic rvalid_o;
    link_params_s params_o;
    int fail_count = 0;
    int n_compared = 0;
    logic [7:0] m [int];
    logic [11:0] ad [11] = '{12'h453, 12'h454, 12'h455, 12'h456, 12'h457, 12'h458, 12'h459, 12'h45a, 12'h46c,
        12'h476, 12'h47d};
    logic [7:0] mt [4][11] = '{'{8'h01, 8'h01, 8'h0f, 8'h01, 8'h0f, 8'h0f, 8'h20, 8'h00, 8'h03, 8'h02, 8'h03},
        '{8'h00, 8'h03, 8'h0f, 8'h01, 8'h0f, 8'h0f, 8'h20, 8'h00, 8'h01, 8'h04, 8'h01},
        '{8'h01, 8'h00, 8'h1f, 8'h00, 8'h0f, 8'h0f, 8'h20, 8'h80, 8'h03, 8'h01, 8'h03},
        '{8'h00, 8'h01, 8'h0f, 8'h00, 8'h0f, 8'h0f, 8'h20, 8'h00, 8'h01, 8'h02, 8'h01}};
    jesd_link_param_config i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .params_o(params_o));
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Write request stays up until the next task drives the bus, so back-to-back writes land on every edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clock_i);
        req_i = '{1'b1, 1'b0, a, d};
        if (a inside {ad}) m[a] = d;
    endtask
    task automatic rd(input logic [11:0] a);
        @(negedge clock_i);
        req_i = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clock_i);
        req_i = '0;
        chk("rvalid", rvalid_o, 1);
        chk("rdata", rdata_o, m.exists(a) ? m[a] : 8'h00);
    endtask
    function automatic link_params_s ep();
        ep.scramble_en = m[12'h453][7];
        ep.lanes = m[12'h453][4:0] + 6'h1;
        ep.octets_per_frame = m[12'h454] + 9'h1;
        ep.frames_per_multiframe = m[12'h455][4:0] + 6'h1;
        ep.converters = m[12'h456] + 9'h1;
        ep.subclass = m[12'h458][7:5] == 0 ? subclass_0 : m[12'h458][7:5] == 1 ? subclass_1 : subclass_other;
        ep.samples_per_frame = m[12'h459][4:0] + 6'h1;
        ep.high_density = m[12'h45a][7];
        ep.deskew_lanes = m[12'h46c];
        ep.enabled_lanes = m[12'h47d];
    endfunction
    task automatic check_all;
        rd(12'h45b);
        foreach (ad[i]) rd(ad[i]);
        chk("params", params_o, ep());
    endtask
    initial begin
        void'($urandom(32'h5781fb3c));
        foreach (ad[i]) m[ad[i]] = 8'h00;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i) sys_rst_i = 0;
        check_all();
        $display("reset test done");
        foreach (mt[k]) begin
            foreach (ad[i]) wr(ad[i], mt[k][i] ^ {i == 0 && $urandom % 2, 1'b0, i == 5 && $urandom % 2, 5'h00});
            check_all();
            $display("mode test %0d done", k);
        end
        repeat (60) wr($urandom % 4 ? ad[$urandom % 11] : 12'h45b, 8'($urandom));
        check_all();
        $display("random test done");
        @(negedge clock_i) sys_rst_i = 1;
        foreach (ad[i]) m[ad[i]] = 8'h00;
        @(negedge clock_i) sys_rst_i = 0;
        check_all();
        $display("second reset test done");
        report_and_stop();
    end
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule // jesd_link_param_config_tb_top
bind jesd_link_param_config link_cfg_sva i_sva (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .params_o(params_o));
